// file: core/lios_top.sv
// Labeller input and output supervisor top level
//
// Summary of operation
// - Driver fault stops the motor, drops healthy flag.
// - Driver faults latch until power-on reset.
// - Four fault flags; healthy only when fault free.
// - Dispense-active high while motor turns and no driver fault is latched.
// - Door rises with dispense-active.
// - Door falls a programmed delay after dispense ends.
// - Dispense during the delay keeps door on.
// - Door enable bit; disabled door stays off.
// - Goods detect finds goods; speed scanner only measures.
// - Fixed mode ignores the scanner.
// - Measuring mode times scanner to goods detect; spacing 10..100 mm.
// - Incremental mode counts scanner pulses as encoder.
// - Goods-count pulses counted in nonstop or external mode.
// - External stop toggles run like the key.
// - Toggle keeps goods count and errors.
// - Label edge, roller lock, paper end, printer ready and roll inputs are active low.
// - Printer ready inhibits labelling, raises an error.
// - Label edge bypasses the filter.
// - Roller lock or paper end reports traction fault.
// - Roll low and take-up full are winder warnings.
// - Energized relay closes make, released closes break.
// - Run relay while running; alarm relays while pending.
// - Enter clears an alarm only once its cause is gone.
// - Isolated copy of dispense-active, optionally inverted.
// - Step clock driven out on its own output.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lios_map.svh"

module lios_top (
  input wire logic core_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic [7:0] addr_i, // Address
  input wire logic [15:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [15:0] rdata_o, // Read data
  input wire logic flt_short_i, // Phase short
  input wire logic flt_temp_i, // Overtemperature
  input wire logic flt_ovolt_i, // Overvoltage
  input wire logic flt_uvolt_i, // Undervoltage
  input wire logic motor_turn_i, // Dispensing
  input wire logic motor_step_i, // Step clock
  input wire logic speed_scanner_input_i, // Scanner
  input wire logic goods_detect_input_i, // Goods
  input wire logic goods_count_input_i, // Count
  input wire logic nonstop_link_in_i, // Link in
  input wire logic ext_stop_i, // Run/stop
  input wire logic label_edge_input_n_i, // Label edge
  input wire logic traction_lock_n_i, // Roller lock
  input wire logic paper_end_n_i, // Paper end
  input wire logic printer_ready_n_i, // Printer ready
  input wire logic supply_roll_low_n_i, // Roll low
  input wire logic takeup_roll_full_n_i, // Take-up full
  output logic motor_enable_o, // Motor on
  output logic driver_healthy_flag_o, // No fault
  output logic [3:0] driver_fault_o, // Fault flags
  output logic dispense_active_o, // Dispensing
  output logic door_actuator_o, // Door drive
  output logic step_clock_o, // Step clock
  output logic nonstop_link_out_o, // Link out
  output logic isolated_dispense_out_o, // Dispense copy
  output logic label_edge_o, // Label edge
  output logic labelling_inhibit_o, // Inhibit
  output logic run_relay_make_o, // Run make
  output logic run_relay_break_o, // Run break
  output logic warning_relay_make_o, // Warning make
  output logic warning_relay_break_o, // Warning break
  output logic error_relay_make_o, // Error make
  output logic error_relay_break_o, // Error break
  output logic goods_pulse_o // Goods pulse
);

  ////////////////////////////////////////////////////////////////////////
  // Input conditioning

  localparam int NIN = 11;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_ff;
  logic [NIN-1:0] sync2_ff;
  logic [NIN-1:0] filt_ff;
  logic [NIN-1:0] filt_d_ff;
  logic [NIN-1:0] rise;

  // Active-low sensors inverted to active high
  assign raw_in = {~label_edge_input_n_i, ~traction_lock_n_i,
                   ~paper_end_n_i, ~printer_ready_n_i,
                   ~supply_roll_low_n_i, ~takeup_roll_full_n_i,
                   speed_scanner_input_i, goods_detect_input_i,
                   goods_count_input_i, nonstop_link_in_i, ext_stop_i};

  // Two-stage synchronisers
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Glitch filter per input; label edge bypasses it for low latency
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_filt
      logic [3:0] cnt_ff;
      always_ff @(posedge core_clk_i)
      begin
        if (!rst_n_i)
        begin
          cnt_ff <= 4'h0;
          filt_ff[gi] <= 1'b0;
        end
        else if (gi == NIN - 1)
        begin
          cnt_ff <= 4'h0;
          filt_ff[gi] <= sync2_ff[gi];
        end
        else if (sync2_ff[gi] == filt_ff[gi])
          cnt_ff <= 4'h0;
        else if (cnt_ff == `LIOS_FILT_LEN - 4'h1)
        begin
          cnt_ff <= 4'h0;
          filt_ff[gi] <= sync2_ff[gi];
        end
        else
          cnt_ff <= cnt_ff + 4'h1;
      end
    end
  endgenerate

  // Delayed copy for edge detection
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      filt_d_ff <= '0;
    else
      filt_d_ff <= filt_ff;
  end
  assign rise = filt_ff & ~filt_d_ff;

  // Named conditioned inputs
  logic lab_edge, trac_lock, paper_end, ready_act, roll_low, roll_full;
  logic spd_rise, gd_rise, gc_rise, stop_rise;
  assign lab_edge = filt_ff[10];
  assign trac_lock = filt_ff[9];
  assign paper_end = filt_ff[8];
  assign ready_act = filt_ff[7];
  assign roll_low = filt_ff[6];
  assign roll_full = filt_ff[5];
  assign spd_rise = rise[4];
  assign gd_rise = rise[3];
  assign gc_rise = rise[2];
  assign stop_rise = rise[0];

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] ctrl_ff;
  logic [7:0] spacing_ff;
  logic [15:0] flap_dly_ff;
  logic run_ff;
  logic enter_ack;
  lios_pkg::lios_mode_type mode;
  assign mode = lios_pkg::lios_mode_type'(ctrl_ff[`LIOS_CTRL_MODE_LSB +: 2]);
  assign enter_ack = wr_i && (addr_i == `LIOS_ADDR_ACK)
                     && wdata_i[`LIOS_ACK_ENTER];

  // Spacing clamped into its legal range
  function automatic logic [7:0] clamp_sp(input logic [7:0] v);
    if (v < `LIOS_SPACING_MIN)
      clamp_sp = `LIOS_SPACING_MIN;
    else if (v > `LIOS_SPACING_MAX)
      clamp_sp = `LIOS_SPACING_MAX;
    else
      clamp_sp = v;
  endfunction

  // Configuration writes
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_ff <= `LIOS_CTRL_RST;
      spacing_ff <= `LIOS_SPACING_RST;
      flap_dly_ff <= `LIOS_FLAP_DLY_RST;
    end
    else if (wr_i)
    begin
      if (addr_i == `LIOS_ADDR_CTRL)
        ctrl_ff <= wdata_i[7:0];
      else if (addr_i == `LIOS_ADDR_SPACING)
        spacing_ff <= clamp_sp(wdata_i[7:0]);
      else if (addr_i == `LIOS_ADDR_FLAP_DLY)
        flap_dly_ff <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Driver fault latch

  logic [3:0] flt_ff;
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      flt_ff <= 4'h0;
    else // Only power-on reset clears
      flt_ff <= flt_ff | {flt_uvolt_i, flt_ovolt_i,
                          flt_temp_i, flt_short_i};
  end

  ////////////////////////////////////////////////////////////////////////
  // Run/stop and alarms

  logic trac_flt, err_cause, warn_cause, err_pend_ff, warn_pend_ff;
  assign trac_flt = trac_lock | paper_end;
  assign err_cause = ready_act | trac_flt | (|flt_ff);
  assign warn_cause = roll_low | roll_full;

  // Run state toggled by stop edge or key write
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      run_ff <= 1'b0;
    else if (stop_rise)
      run_ff <= ~run_ff;
    else if (wr_i && addr_i == `LIOS_ADDR_CTRL && wdata_i[`LIOS_CTRL_RUN_KEY])
      run_ff <= ~run_ff;
  end

  // Pending alarms; cause wins over enter
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      err_pend_ff <= 1'b0;
      warn_pend_ff <= 1'b0;
    end
    else
    begin
      if (err_cause)
        err_pend_ff <= 1'b1;
      else if (enter_ack)
        err_pend_ff <= 1'b0;
      if (warn_cause)
        warn_pend_ff <= 1'b1;
      else if (enter_ack)
        warn_pend_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Speed measurement and goods counting

  logic [15:0] meas_cnt_ff, meas_val_ff, goods_cnt_ff, events_ff, tick_ff;
  lios_pkg::lios_meas_type mst_ff;
  localparam logic [15:0] TICK = 16'(`LIOS_TICK_CYC);

  // Millisecond tick
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || tick_ff == TICK - 16'h1)
      tick_ff <= 16'h0;
    else
      tick_ff <= tick_ff + 16'h1;
  end

  // Measuring interval or encoder pulses per tick
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      mst_ff <= lios_pkg::LIOS_M_IDLE;
      meas_cnt_ff <= 16'h0;
      meas_val_ff <= 16'h0;
    end
    else
    begin
      case (mode)
        lios_pkg::LIOS_MEASURE:
        begin
          case (mst_ff)
            lios_pkg::LIOS_M_IDLE:
              if (spd_rise)
              begin
                mst_ff <= lios_pkg::LIOS_M_RUN;
                meas_cnt_ff <= 16'h0;
              end
            lios_pkg::LIOS_M_RUN:
              if (gd_rise)
              begin
                meas_val_ff <= meas_cnt_ff;
                mst_ff <= lios_pkg::LIOS_M_DONE;
              end
              else if (meas_cnt_ff != 16'hFFFF)
                meas_cnt_ff <= meas_cnt_ff + 16'h1;
            default:
              mst_ff <= lios_pkg::LIOS_M_IDLE;
          endcase
        end
        lios_pkg::LIOS_INCR:
        begin
          mst_ff <= lios_pkg::LIOS_M_IDLE;
          if (tick_ff == TICK - 16'h1)
          begin
            meas_val_ff <= meas_cnt_ff + {15'h0, spd_rise};
            meas_cnt_ff <= 16'h0;
          end
          else if (spd_rise)
            meas_cnt_ff <= meas_cnt_ff + 16'h1;
        end
        default: // Fixed speed: scanner ignored
        begin
          mst_ff <= lios_pkg::LIOS_M_IDLE;
          meas_cnt_ff <= 16'h0;
        end
      endcase
    end
  end

  // Goods and event counters
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      goods_cnt_ff <= 16'h0;
      events_ff <= 16'h0;
      goods_pulse_o <= 1'b0;
    end
    else
    begin
      goods_pulse_o <= gd_rise;
      if (gd_rise)
        goods_cnt_ff <= goods_cnt_ff + 16'h1;
      if (gc_rise && (ctrl_ff[`LIOS_CTRL_NONSTOP] ||
                      ctrl_ff[`LIOS_CTRL_CNT_EXT]))
        events_ff <= events_ff + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dispense and door actuator

  logic [15:0] dly_ms_ff;
  logic feed;
  assign feed = motor_turn_i && !(|flt_ff);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      dispense_active_o <= 1'b0;
      door_actuator_o <= 1'b0;
      isolated_dispense_out_o <= 1'b0;
      step_clock_o <= 1'b0;
      dly_ms_ff <= 16'h0;
    end
    else
    begin
      dispense_active_o <= feed;
      isolated_dispense_out_o <= feed ^ ctrl_ff[`LIOS_CTRL_ISOLATED_DISPENSE_OUT_INV];
      step_clock_o <= motor_step_i && feed;
      if (!ctrl_ff[`LIOS_CTRL_FLAP_EN])
      begin
        door_actuator_o <= 1'b0;
        dly_ms_ff <= 16'h0;
      end
      else if (feed)
      begin
        door_actuator_o <= 1'b1;
        dly_ms_ff <= flap_dly_ff;
      end
      else if (dly_ms_ff == 16'h0)
        door_actuator_o <= 1'b0;
      else if (tick_ff == TICK - 16'h1)
        dly_ms_ff <= dly_ms_ff - 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs and relays

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      motor_enable_o <= 1'b0;
      driver_healthy_flag_o <= 1'b0;
      driver_fault_o <= 4'h0;
      label_edge_o <= 1'b0;
      labelling_inhibit_o <= 1'b1;
      nonstop_link_out_o <= 1'b0;
      run_relay_make_o <= 1'b0;
      run_relay_break_o <= 1'b1;
      warning_relay_make_o <= 1'b0;
      warning_relay_break_o <= 1'b1;
      error_relay_make_o <= 1'b0;
      error_relay_break_o <= 1'b1;
    end
    else
    begin
      motor_enable_o <= !(|flt_ff) && !(|{flt_uvolt_i, flt_ovolt_i,
                        flt_temp_i, flt_short_i});
      driver_healthy_flag_o <= !(|flt_ff) && !(|{flt_uvolt_i,
                               flt_ovolt_i, flt_temp_i, flt_short_i});
      driver_fault_o <= flt_ff;
      label_edge_o <= lab_edge;
      labelling_inhibit_o <= ready_act || !run_ff || (|flt_ff);
      nonstop_link_out_o <= ctrl_ff[`LIOS_CTRL_NSO];
      run_relay_make_o <= run_ff;
      run_relay_break_o <= !run_ff;
      warning_relay_make_o <= warn_pend_ff;
      warning_relay_break_o <= !warn_pend_ff;
      error_relay_make_o <= err_pend_ff;
      error_relay_break_o <= !err_pend_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !rd_i)
      rdata_o <= 16'h0;
    else if (addr_i == `LIOS_ADDR_CTRL)
      rdata_o <= {8'h0, ctrl_ff};
    else if (addr_i == `LIOS_ADDR_SPACING)
      rdata_o <= {8'h0, spacing_ff};
    else if (addr_i == `LIOS_ADDR_FLAP_DLY)
      rdata_o <= flap_dly_ff;
    else if (addr_i == `LIOS_ADDR_CAUSE)
      rdata_o <= {7'h0, lab_edge, trac_lock, paper_end, ready_act,
                  roll_low, roll_full, trac_flt, err_cause, warn_cause};
    else if (addr_i == `LIOS_ADDR_STATUS)
      rdata_o <= {9'h0, run_ff, warn_pend_ff, err_pend_ff, flt_ff};
    else if (addr_i == `LIOS_ADDR_MEAS)
      rdata_o <= meas_val_ff;
    else if (addr_i == `LIOS_ADDR_GOODS)
      rdata_o <= goods_cnt_ff;
    else if (addr_i == `LIOS_ADDR_EVENTS)
      rdata_o <= events_ff;
    else
      rdata_o <= 16'h0;
  end

endmodule

`default_nettype wire

// file: core/lios_map.svh
// Labeller supervisor constants
`ifndef LIOS_MAP_SVH
`define LIOS_MAP_SVH

// Register byte addresses
`define LIOS_ADDR_CTRL 8'h00
`define LIOS_ADDR_SPACING 8'h04
`define LIOS_ADDR_FLAP_DLY 8'h08
`define LIOS_ADDR_ACK 8'h0C
`define LIOS_ADDR_CAUSE 8'h10
`define LIOS_ADDR_STATUS 8'h14
`define LIOS_ADDR_MEAS 8'h18
`define LIOS_ADDR_GOODS 8'h1C
`define LIOS_ADDR_EVENTS 8'h20

// Control register fields
`define LIOS_CTRL_MODE_LSB 0
`define LIOS_CTRL_FLAP_EN 2
`define LIOS_CTRL_ISOLATED_DISPENSE_OUT_INV 3
`define LIOS_CTRL_CNT_EXT 4
`define LIOS_CTRL_NONSTOP 5
`define LIOS_CTRL_RUN_KEY 6
`define LIOS_CTRL_NSO 7

// Acknowledge register fields
`define LIOS_ACK_ENTER 0

// Reset values
`define LIOS_CTRL_RST 8'h04
`define LIOS_SPACING_RST 8'h0A
`define LIOS_FLAP_DLY_RST 16'h0064

// Scanner spacing limits in millimetres
`define LIOS_SPACING_MIN 8'h0A
`define LIOS_SPACING_MAX 8'h64

// One millisecond in 25 ns cycles
`define LIOS_TICK_CYC 40000

// Glitch filter length in cycles
`define LIOS_FILT_LEN 4'h4

`endif

// file: core/lios_pkg.sv
// Labeller supervisor types
package lios_pkg;

  // Speed measurement modes
  typedef enum logic [1:0] {
    LIOS_FIXED = 2'h0,
    LIOS_MEASURE = 2'h1,
    LIOS_INCR = 2'h3
  } lios_mode_type;

  // Measuring scanner states, Gray coded
  typedef enum logic [1:0] {
    LIOS_M_IDLE = 2'h0,
    LIOS_M_RUN = 2'h1,
    LIOS_M_DONE = 2'h3
  } lios_meas_type;

endpackage

// file: dv/lios_properties.sv
// Port-level assertions for the labeller supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lios_map.svh"

module lios_properties (
  input wire logic core_clk_i, // Clock
  input wire logic rst_n_i, // Reset, low
  input wire logic [7:0] addr_i, // Address
  input wire logic [15:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic flt_short_i, // Phase short
  input wire logic flt_temp_i, // Overtemperature
  input wire logic flt_ovolt_i, // Overvoltage
  input wire logic flt_uvolt_i, // Undervoltage
  input wire logic motor_turn_i, // Motor turning
  input wire logic motor_step_i, // Step clock in
  input wire logic label_edge_input_n_i, // Label edge, low
  input wire logic printer_ready_n_i, // Printer ready, low
  input wire logic motor_enable_o, // Motor on
  input wire logic driver_healthy_flag_o, // Healthy
  input wire logic [3:0] driver_fault_o, // Fault flags
  input wire logic dispense_active_o, // Feeding
  input wire logic door_actuator_o, // Door drive
  input wire logic step_clock_o, // Step clock out
  input wire logic label_edge_o, // Label edge out
  input wire logic labelling_inhibit_o, // Inhibit
  input wire logic run_relay_make_o, // Run make
  input wire logic run_relay_break_o, // Run break
  input wire logic warning_relay_make_o, // Warning make
  input wire logic warning_relay_break_o, // Warning break
  input wire logic error_relay_make_o, // Error make
  input wire logic error_relay_break_o, // Error break
  input wire logic goods_pulse_o // Goods pulse
);
  logic [2:0] up_ff; // Cycles since reset, saturating
  logic door_en_ff; // Door enable shadow
  logic dly_nz_ff; // Door delay nonzero

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since reset
  always_ff @(posedge core_clk_i)
    if (!rst_n_i)
      up_ff <= 3'h0;
    else if (up_ff != 3'h7)
      up_ff <= up_ff + 3'h1;

  // Door setting shadows
  always_ff @(posedge core_clk_i)
    if (!rst_n_i)
      door_en_ff <= 1'b1;
    else if (wr_i && addr_i == `LIOS_ADDR_CTRL)
      door_en_ff <= wdata_i[`LIOS_CTRL_FLAP_EN];
  always_ff @(posedge core_clk_i)
    if (!rst_n_i)
      dly_nz_ff <= 1'b1;
    else if (wr_i && addr_i == `LIOS_ADDR_FLAP_DLY)
      dly_nz_ff <= (wdata_i != 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  fault_stop_a: assert property (
    (flt_short_i | flt_temp_i | flt_ovolt_i | flt_uvolt_i)
    |=> !motor_enable_o && !driver_healthy_flag_o)
    else $error("motor kept on after driver fault");
  fault_latch_a: assert property (
    driver_fault_o != 4'h0 |=> (driver_fault_o & $past(driver_fault_o))
    == $past(driver_fault_o)) else $error("driver fault flag released");
  healthy_flag_a: assert property (
    driver_fault_o != 4'h0 |-> !driver_healthy_flag_o)
    else $error("healthy flag set with fault present");
  feed_src_a: assert property (
    dispense_active_o |-> $past(motor_turn_i))
    else $error("dispense active without motor turning");
  door_rise_a: assert property (
    $rose(dispense_active_o) && door_en_ff |-> door_actuator_o)
    else $error("door not raised with dispense");
  door_hold_a: assert property (
    $fell(dispense_active_o) && door_en_ff && dly_nz_ff |-> door_actuator_o)
    else $error("door dropped together with dispense");
  door_off_a: assert property (
    !door_en_ff && !$past(door_en_ff) |-> !door_actuator_o)
    else $error("door driven while disabled");
  step_src_a: assert property (
    step_clock_o |-> $past(motor_step_i))
    else $error("step clock without motor step");
  relay_pair_a: assert property (
    run_relay_make_o != run_relay_break_o &&
    warning_relay_make_o != warning_relay_break_o &&
    error_relay_make_o != error_relay_break_o)
    else $error("relay contacts not complementary");
  ready_inh_a: assert property (
    (!printer_ready_n_i) [*8] |=> labelling_inhibit_o)
    else $error("labelling allowed with printer ready active");
  edge_lat_a: assert property (
    up_ff == 3'h7 |-> label_edge_o == !$past(label_edge_input_n_i, 4))
    else $error("label edge latency wrong");
  pulse_one_a: assert property (
    goods_pulse_o |=> !goods_pulse_o)
    else $error("goods pulse longer than one cycle");
endmodule
`default_nettype wire

// file: dv/lios_far_model.sv
// Labeller sensors and second labeller on the far side
`timescale 1ns/1ps
`default_nettype none

module lios_far_model (
  input wire logic [5:0] cond_i, // Edge,lock,paper,ready,low,full
  input wire logic link_i, // Nonstop link from device
  output logic [5:0] line_n_o, // Sensor lines, low when active
  output logic link_o // Nonstop link back to device
);
  // Sensors pull lines low while active
  assign line_n_o = ~cond_i;
  // Second labeller echoes the link
  assign link_o = link_i;
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the labeller supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lios_map.svh"

module tb;
  logic core_clk_i, rst_n_i, wr_i, rd_i, motor_turn_i, motor_step_i;
  logic spd, gdet, stop, lnk_o, lnk_i, men, hlt, feed, door, step, iso;
  logic edge_o, inh, run_mk, run_bk, wrn_mk, wrn_bk, err_mk, err_bk, gp;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, rdata_o, rd_val;
  logic [3:0] flt, fault;
  logic [5:0] cond, ln;
  logic [9:0] rows [7];
  int error_cnt, check_count, k, n;

  lios_top u_lios_top (.core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .flt_short_i(flt[0]), .flt_temp_i(flt[1]),
    .flt_ovolt_i(flt[2]), .flt_uvolt_i(flt[3]), .motor_turn_i,
    .motor_step_i,
    .speed_scanner_input_i(spd), .goods_detect_input_i(gdet),
    .goods_count_input_i(1'b0), .nonstop_link_in_i(lnk_i),
    .ext_stop_i(stop), .label_edge_input_n_i(ln[5]),
    .traction_lock_n_i(ln[4]), .paper_end_n_i(ln[3]),
    .printer_ready_n_i(ln[2]), .supply_roll_low_n_i(ln[1]),
    .takeup_roll_full_n_i(ln[0]), .motor_enable_o(men),
    .driver_healthy_flag_o(hlt), .driver_fault_o(fault),
    .dispense_active_o(feed), .door_actuator_o(door),
    .step_clock_o(step), .nonstop_link_out_o(lnk_o),
    .isolated_dispense_out_o(iso), .label_edge_o(edge_o),
    .labelling_inhibit_o(inh), .run_relay_make_o(run_mk),
    .run_relay_break_o(run_bk), .warning_relay_make_o(wrn_mk),
    .warning_relay_break_o(wrn_bk), .error_relay_make_o(err_mk),
    .error_relay_break_o(err_bk), .goods_pulse_o(gp));

  lios_far_model u_lios_far_model (.cond_i(cond), .link_i(lnk_o),
    .line_n_o(ln), .link_o(lnk_i));

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 25 ns
  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Wait edges, then settle
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  // Data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
  endtask

  task automatic chk1(input string s, input logic e, input logic g);
    chk16(s, {15'h0000, e}, {15'h0000, g});
  endtask

  task automatic chk16(input string s, input logic [15:0] e, g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    // Rows: conditions, cause bits, inhibit
    rows = '{10'h200, 10'h10C, 10'h08C, 10'h045, 10'h022, 10'h012, 10'h000};
    error_cnt = 0;
    check_count = 0;
    {wr_i, rd_i, motor_turn_i, motor_step_i, spd, gdet, stop} = 7'h00;
    {addr_i, wdata_i, flt, cond, rst_n_i} = 35'h0;
    tick(3);
    chk1("inhibit rst", 1'b1, inh);
    chk1("run break rst", 1'b1, run_bk);
    chk1("err break rst", 1'b1, err_bk);
    rst_n_i <= 1'b1;
    rd(`LIOS_ADDR_CTRL);
    chk16("ctrl rst", 16'h0004, rd_val);
    rd(`LIOS_ADDR_FLAP_DLY);
    chk16("delay rst", 16'h0064, rd_val);
    rd(8'h24);
    chk16("unmapped", 16'h0000, rd_val);
    wr(`LIOS_ADDR_SPACING, 16'h0005);
    rd(`LIOS_ADDR_SPACING);
    chk16("spacing low", 16'h000A, rd_val);
    wr(`LIOS_ADDR_SPACING, 16'h00C8);
    rd(`LIOS_ADDR_SPACING);
    chk16("spacing high", 16'h0064, rd_val);
    wr(`LIOS_ADDR_CTRL, 16'h0044);
    tick(2);
    chk1("run relay", 1'b1, run_mk);
    $display("test reset done");
    // Sensor rows
    for (k = 0; k < 7; k++)
    begin
      cond <= rows[k][9:4];
      tick(12);
      rd(`LIOS_ADDR_CAUSE);
      chk16("cause", {7'h00, rows[k][9:1]}, rd_val);
      chk1("inhibit", rows[k][0], inh);
      chk1("edge", rows[k][9], edge_o);
    end
    wr(`LIOS_ADDR_ACK, 16'h0001);
    tick(2);
    chk1("err cleared", 1'b0, err_mk);
    $display("test sensors done");
    // Enter only counts once cause has gone
    cond <= 6'h02;
    tick(12);
    chk1("warn set", 1'b1, wrn_mk);
    wr(`LIOS_ADDR_ACK, 16'h0001);
    tick(2);
    chk1("warn kept", 1'b1, wrn_mk);
    cond <= 6'h00;
    tick(12);
    chk1("warn pending", 1'b1, wrn_mk);
    wr(`LIOS_ADDR_ACK, 16'h0001);
    tick(2);
    chk1("warn clear", 1'b0, wrn_mk);
    cond <= 6'h02;
    $display("test ack done");
    // Stop: glitch, then two presses
    stop <= 1'b1;
    tick(2);
    stop <= 1'b0;
    tick(12);
    chk1("glitch", 1'b1, run_mk);
    for (k = 0; k < 2; k++)
    begin
      stop <= 1'b1;
      tick(20);
      stop <= 1'b0;
      tick(12);
      chk1("stop toggle", k[0], run_mk);
      chk1("warn on stop", 1'b1, wrn_mk);
    end
    cond <= 6'h00;
    $display("test stop done");
    // Scanner: fixed ignores, measuring times
    wr(`LIOS_ADDR_CTRL, 16'h0004);
    spd <= 1'b1;
    tick(10);
    spd <= 1'b0;
    tick(10);
    rd(`LIOS_ADDR_MEAS);
    chk16("meas fixed", 16'h0000, rd_val);
    wr(`LIOS_ADDR_CTRL, 16'h0005);
    spd <= 1'b1;
    tick(50);
    gdet <= 1'b1;
    tick(20);
    {spd, gdet} <= 2'h0;
    tick(10);
    rd(`LIOS_ADDR_MEAS);
    chk1("meas", 1'b1, rd_val >= 16'd49 && rd_val <= 16'd51);
    for (k = 0; k < 3; k++)
    begin
      wr(`LIOS_ADDR_CTRL, (k == 2) ? 16'h0007 : 16'h0004 + k[15:0]);
      gdet <= 1'b1;
      n = 0;
      repeat (24)
      begin
        tick(1);
        if (gp === 1'b1)
          n++;
        gdet <= (n == 0);
      end
      chk1("goods pulse", 1'b1, n == 1);
    end
    $display("test modes done");
    // Door with no delay, inversion, disable and step clock
    wr(`LIOS_ADDR_CTRL, 16'h0004);
    wr(`LIOS_ADDR_FLAP_DLY, 16'h0000);
    motor_turn_i <= 1'b1;
    tick(5);
    chk1("feed on", 1'b1, feed);
    chk1("door on", 1'b1, door);
    chk1("iso normal", 1'b1, iso);
    motor_step_i <= 1'b1;
    tick(1);
    motor_step_i <= 1'b0;
    chk1("step out", 1'b1, step);
    tick(1);
    chk1("step low", 1'b0, step);
    motor_turn_i <= 1'b0;
    tick(3);
    chk1("feed off", 1'b0, feed);
    chk1("door off", 1'b0, door);
    wr(`LIOS_ADDR_CTRL, 16'h0088);
    tick(3);
    chk1("iso invert", 1'b1, iso);
    chk1("link out", 1'b1, lnk_o);
    motor_turn_i <= 1'b1;
    tick(5);
    chk1("door disabled", 1'b0, door);
    motor_turn_i <= 1'b0;
    // Door delay of 1 ms, retriggered
    wr(`LIOS_ADDR_CTRL, 16'h0004);
    wr(`LIOS_ADDR_FLAP_DLY, 16'h0001);
    motor_turn_i <= 1'b1;
    tick(5);
    motor_turn_i <= 1'b0;
    tick(100);
    chk1("door delay", 1'b1, door);
    motor_turn_i <= 1'b1;
    n = 0;
    repeat (20)
    begin
      tick(1);
      if (door !== 1'b1)
        n++;
    end
    chk1("door retrigger", 1'b1, n == 0);
    motor_turn_i <= 1'b0;
    n = 0;
    while (door === 1'b1 && n < 90000)
    begin
      tick(1);
      n++;
    end
    if (n >= 90000)
    begin
      $display("timeout door delay");
      error_cnt++;
      finish_test();
    end
    chk1("delay length", 1'b1, n <= 80001);
    $display("test door done");
    // Each driver fault latches until reset
    for (k = 0; k < 4; k++)
    begin
      flt <= 4'h1 << k;
      tick(1);
      flt <= 4'h0;
      tick(2);
      chk16("fault", {12'h000, 4'h1 << k}, {12'h000, fault});
      chk1("healthy", 1'b0, hlt);
      chk1("motor off", 1'b0, men);
      wr(`LIOS_ADDR_ACK, 16'h0001);
      motor_turn_i <= 1'b1;
      tick(3);
      chk1("no feed", 1'b0, feed);
      rd(`LIOS_ADDR_STATUS);
      chk16("status", {12'h000, 4'h1 << k}, {12'h000, rd_val[3:0]});
      motor_turn_i <= 1'b0;
      rst_n_i <= 1'b0;
      tick(3);
      rst_n_i <= 1'b1;
      tick(3);
      chk1("healthy again", 1'b1, hlt);
    end
    $display("test faults done");
    finish_test();
  end
endmodule

bind lios_top lios_properties u_lios_properties (.*);
`default_nettype wire
